// file: verilog/tcp_pkg.sv
// Constants shared by the timer/counter with PWM block.
package tcp_pkg;
   // ------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [7:0] IDX_MODE   = 8'h88;
   localparam logic [7:0] IDX_COUNT  = 8'h89;
   localparam logic [7:0] IDX_RELOAD = 8'h8a;
   localparam logic [7:0] IDX_STATUS = 8'h8b;
   localparam int         ADR_W      = 10;
   // ------------------------------------------------------------------
   // Mode register fields
   // ------------------------------------------------------------------
   localparam int B_PWM    = 0;
   localparam int B_TOGGLE = 1;
   localparam int B_ALOAD  = 2;
   localparam int B_CKS    = 3;
   localparam int B_RATE   = 4;
   localparam int B_RUN    = 7;
   // ------------------------------------------------------------------
   // Status register fields
   // ------------------------------------------------------------------
   localparam int B_IRQ = 0;
   localparam int B_IEN = 1;
   // ------------------------------------------------------------------
   // Values
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] MASK_256 = 8'hff;
   localparam logic [7:0] MASK_64  = 8'h3f;
   localparam logic [7:0] MASK_32  = 8'h1f;
   localparam logic [7:0] MASK_16  = 8'h0f;
   localparam logic [7:0] ONE_BYTE = 8'h01;
endpackage

// file: verilog/tcp_timer.sv
// Eight-bit timer/event counter with buzzer and PWM output.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
// Notes on behaviour
// - In PWM mode on the internal clock the wrap modulus is 256, 64, 32 or 16 by two bits.
// - PWM off or external clock: boundary 256, whole range 0x00-0xFF valid.
// - With auto-reload on and PWM off, overflow copies the reload value into the count.
// - Reload writes go to a holding buffer, moved to active at overflow.
// - PWM enabled means auto-reload acts enabled; the bit picks modulus only.
// - Toggle output flips each overflow with PWM off; pin leaves general-purpose use.
// - PWM output high while count below active reload, low otherwise.
// - At each PWM cycle start the count wraps to zero, output high unless reload is zero.
// - Reload zero keeps PWM low; duty is reload over modulus.
// - A new duty written mid-period takes effect in the next period.
// - In PWM mode each overflow still raises the timer request.
// - Clearing run enable stops counting, buzzer and PWM together.
// - PWM enable routes PWM to the shared pin, disabling its GPIO use.
// - Reload register is write-only and reads as zero.
// - Rate field divides the core clock by 256 down to 2.
// - On overflow the counter keeps counting and sets the request flag.
// - External source counts falling edges of the event input.
// - External source ignores rate and holds the pin request at zero.
module tcp_timer
   import tcp_pkg::*;
(
   input  wire logic             MCLK,
   input  wire logic             RESET,
   input  wire logic             WB_CYC_I,
   input  wire logic             WB_STB_I,
   input  wire logic             WB_WE_I,
   input  wire logic [ADR_W-1:0] WB_ADR_I,
   input  wire logic [3:0]       WB_SEL_I,
   input  wire logic [31:0]      WB_DAT_I,
   output logic      [31:0]      WB_DAT_O,
   output logic                  WB_ACK_O,
   input  wire logic             EXT_EVENT_IN,
   output logic                  EXT_PIN_IRQ,
   output logic                  TIMER_IRQ_REQ,
   output logic                  TIMER_IRQ_EN,
   output logic                  BUZ_PWM_OUT,
   output logic                  PIN_ALT_SEL
);
   // ------------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------------
   logic [7:0] mode_q;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [7:0] hold_q;
   logic [7:0] act_q;
   logic       irq_q;
   logic       ien_q;
   logic       ack_q;
   logic [31:0] rdat_q;
   logic       req;
   logic       wr;
   logic [7:0] wdat;
   logic [7:0] rsel;

   assign req  = WB_CYC_I & WB_STB_I;
   // Writes land on the edge where the master sees ack, never earlier.
   assign wr   = req & WB_WE_I & ack_q & WB_SEL_I[0];
   assign wdat = WB_DAT_I[7:0];

   always_comb begin
      rsel = RST_BYTE;
      if (WB_ADR_I == {IDX_MODE, 2'b00}) begin
         rsel = mode_q;
      end else if (WB_ADR_I == {IDX_COUNT, 2'b00}) begin
         rsel = cnt_q;
      end else if (WB_ADR_I == {IDX_STATUS, 2'b00}) begin
         rsel = {6'h00, ien_q, irq_q};
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= req & ~ack_q;
         rdat_q <= {24'h00_0000, rsel};
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         mode_q <= RST_BYTE;
      end else if (wr && WB_ADR_I == {IDX_MODE, 2'b00}) begin
         mode_q <= wdat;
      end
   end

   // ------------------------------------------------------------------
   // Event input synchroniser
   // ------------------------------------------------------------------
   logic sy1_q;
   logic sy2_q;
   logic sy3_q;
   logic lvl_q;
   logic ext_fall;

   assign ext_fall = lvl_q & ~sy2_q & ~sy3_q;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         sy1_q <= 1'b1;
         sy2_q <= 1'b1;
         sy3_q <= 1'b1;
         lvl_q <= 1'b1;
      end else begin
         sy1_q <= EXT_EVENT_IN;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         if (sy2_q == sy3_q) begin
            lvl_q <= sy3_q;
         end
      end
   end

   // ------------------------------------------------------------------
   // Mode decode and prescaler
   // ------------------------------------------------------------------
   logic       run;
   logic       pwm;
   logic       tog;
   logic       aload;
   logic       cks;
   logic [2:0] rate;
   logic [7:0] div_q;
   logic [7:0] pmask;
   logic       pre_tick;
   logic       tick;
   logic [7:0] mod_mask;
   logic       ovf;

   assign run   = mode_q[B_RUN];
   assign pwm   = mode_q[B_PWM];
   assign tog   = mode_q[B_TOGGLE];
   assign aload = mode_q[B_ALOAD];
   assign cks   = mode_q[B_CKS];
   assign rate  = mode_q[B_RATE +: 3];

   // The prescaler runs freely, so the first tick after enabling may come
   // early by up to one divided period.
   assign pmask    = MASK_256 >> rate;
   assign pre_tick = (div_q & pmask) == pmask;
   assign tick     = run & (cks ? ext_fall : pre_tick);

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         div_q <= RST_BYTE;
      end else begin
         div_q <= div_q + ONE_BYTE;
      end
   end

   always_comb begin
      mod_mask = MASK_256;
      if (pwm && !cks) begin
         case ({aload, tog})
            2'b00:   mod_mask = MASK_256;
            2'b01:   mod_mask = MASK_64;
            2'b10:   mod_mask = MASK_32;
            2'b11:   mod_mask = MASK_16;
            default: mod_mask = MASK_256;
         endcase
      end
   end

   assign ovf = tick && ((cnt_q & mod_mask) == mod_mask);

   // ------------------------------------------------------------------
   // Counter and reload buffers
   // ------------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      if (wr && WB_ADR_I == {IDX_COUNT, 2'b00}) begin
         cnt_d = wdat;
      end else if (ovf) begin
         if (pwm) begin
            cnt_d = RST_BYTE;
         end else if (aload) begin
            cnt_d = hold_q;
         end else begin
            cnt_d = RST_BYTE;
         end
      end else if (tick) begin
         cnt_d = cnt_q + ONE_BYTE;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         cnt_q <= RST_BYTE;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         hold_q <= RST_BYTE;
         act_q  <= RST_BYTE;
      end else begin
         if (wr && WB_ADR_I == {IDX_RELOAD, 2'b00}) begin
            hold_q <= wdat;
         end
         if (ovf) begin
            act_q <= hold_q;
         end
      end
   end

   // Set wins over a software clear arriving in the same cycle.
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         irq_q <= 1'b0;
         ien_q <= 1'b0;
      end else begin
         if (wr && WB_ADR_I == {IDX_STATUS, 2'b00}) begin
            irq_q <= wdat[B_IRQ] | ovf;
            ien_q <= wdat[B_IEN];
         end else if (ovf) begin
            irq_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Buzzer, PWM and pin outputs
   // ------------------------------------------------------------------
   logic       tog_q;
   logic       pwm_q;
   logic       ext_irq_q;
   logic       out_q;
   logic       alt_q;
   logic       tog_d;
   logic       pwm_d;
   logic [7:0] act_ref;

   // The duty taking over at this overflow already drives count zero, so a
   // period never opens with a level left from the old duty.
   assign act_ref = ovf ? hold_q : act_q;
   assign tog_d   = (ovf && tog && !pwm) ? ~tog_q : tog_q;
   assign pwm_d   = run && ((cnt_d & mod_mask) < (act_ref & mod_mask));

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         tog_q <= 1'b0;
         pwm_q <= 1'b0;
         out_q <= 1'b0;
         alt_q <= 1'b0;
      end else begin
         tog_q <= tog_d;
         pwm_q <= pwm_d;
         out_q <= pwm ? pwm_d : tog_d;
         alt_q <= pwm | tog;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ext_irq_q <= 1'b0;
      end else begin
         ext_irq_q <= ext_fall & ~cks;
      end
   end

   assign WB_ACK_O      = ack_q;
   assign WB_DAT_O      = rdat_q;
   assign TIMER_IRQ_REQ = irq_q;
   assign TIMER_IRQ_EN  = ien_q;
   assign EXT_PIN_IRQ   = ext_irq_q;
   assign BUZ_PWM_OUT   = out_q;
   assign PIN_ALT_SEL   = alt_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RESET);

   logic cnt_wr;
   assign cnt_wr = wr && WB_ADR_I == {IDX_COUNT, 2'b00};

   sequence s_ovf_quiet;
      ovf && !cnt_wr;
   endsequence

   chk_pwm_wrap_zero: assert property (
      s_ovf_quiet ##0 pwm |=> cnt_q == RST_BYTE)
      else $error("PWM overflow did not wrap to zero.");

   chk_full_range: assert property (
      tick && !cnt_wr && (!pwm || cks) && cnt_q == MASK_64 |=> !irq_q
      || $past(irq_q) || cnt_q == MASK_64 + ONE_BYTE)
      else $error("Count stopped short of full range.");

   chk_reload_copy: assert property (
      s_ovf_quiet ##0 (aload && !pwm) |=> cnt_q == $past(hold_q))
      else $error("Reload value not copied on overflow.");

   chk_active_hold: assert property (
      !ovf |=> $stable(act_q))
      else $error("Active reload changed away from overflow.");

   chk_buzzer_toggle: assert property (
      ovf && tog && !pwm |=> tog_q != $past(tog_q))
      else $error("Buzzer output did not toggle.");

   chk_pwm_level: assert property (
      run && pwm ##1 run && pwm && $stable(mode_q) |->
      pwm_q == ((cnt_q & mod_mask) < (act_q & mod_mask)))
      else $error("PWM level does not match compare.");

   chk_irq_raise: assert property (
      ovf |=> irq_q)
      else $error("Overflow did not raise request.");

   chk_stop_all: assert property (
      !run && !cnt_wr |=> $stable(cnt_q) && !pwm_q)
      else $error("Stopped counter still active.");

   chk_ext_quiet: assert property (
      cks ##1 cks |-> !ext_irq_q)
      else $error("Pin request raised with external clock.");

endmodule // tcp_timer

// file: sim/tcp_pin_model.sv
// Pin-side model: event source and buzzer/PWM pin observer.
`timescale 1ns/100ps
module tcp_pin_model (
   input  wire logic clk,
   input  wire logic pin_out,
   input  wire logic clr,
   output logic      ev_n,
   output int        last_hi,
   output int        edges
);
   // ------------------------------------------------------------
   // Pin behaviour
   // ------------------------------------------------------------
   logic last_q;
   int   run;
   // The event line idles high, as a pulled-up input would.
   initial begin
      ev_n = 1'b1;
      last_hi = 0;
      edges = 0;
      run = 0;
   end
   always @(posedge clk) begin
      last_q <= pin_out;
      run <= (pin_out === 1'b1) ? run + 1 : 0;
      if (clr)
         last_hi <= 0;
      else if (last_q === 1'b1 && pin_out === 1'b0)
         last_hi <= run;
      edges <= clr ? 0 : edges + int'(pin_out !== last_q);
   end
   // Each edge is held four cycles so the synchroniser sees it.
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk) ev_n <= 1'b0;
         repeat (4) @(posedge clk);
         ev_n <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule // tcp_pin_model

// file: sim/tcp_timer_bench.sv
// Self-checking bench for the timer/counter with PWM.
`timescale 1ns/100ps
module tcp_timer_bench;
   import tcp_pkg::*;
   // ------------------------------------------------------------
   // Harness
   // ------------------------------------------------------------
   localparam logic [9:0] A_MODE   = {IDX_MODE, 2'b00};
   localparam logic [9:0] A_COUNT  = {IDX_COUNT, 2'b00};
   localparam logic [9:0] A_RELOAD = {IDX_RELOAD, 2'b00};
   localparam logic [9:0] A_STAT   = {IDX_STATUS, 2'b00};
   logic             MCLK, RESET, cyc_i, we_i, clr, ack, ev_n;
   logic             pin_irq, irq, ien, pin, alt;
   logic [ADR_W-1:0] adr_i;
   logic [31:0]      dat_i, dat_o;
   int               n_mismatch, n_tests, cyc, n_pin_irq, last_hi, edges;
   int               mods[4] = '{256, 64, 32, 16};
   tcp_timer u_tcp_timer (.MCLK(MCLK), .RESET(RESET), .WB_CYC_I(cyc_i),
      .WB_STB_I(cyc_i), .WB_WE_I(we_i), .WB_ADR_I(adr_i),
      .WB_SEL_I(4'h1), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .EXT_EVENT_IN(ev_n), .EXT_PIN_IRQ(pin_irq),
      .TIMER_IRQ_REQ(irq), .TIMER_IRQ_EN(ien), .BUZ_PWM_OUT(pin),
      .PIN_ALT_SEL(alt));
   tcp_pin_model u_tcp_pin_model (.clk(MCLK), .pin_out(pin), .clr(clr),
      .ev_n(ev_n), .last_hi(last_hi), .edges(edges));
   initial begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      n_pin_irq <= n_pin_irq + int'(pin_irq === 1'b1);
   end
   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // A bus cycle waits for its ack; a lost ack ends the run.
   task automatic wb(logic we, logic [9:0] a, logic [7:0] d,
                     output logic [7:0] q);
      int i;
      @(posedge MCLK);
      cyc_i <= 1'b1;
      we_i <= we;
      adr_i <= a;
      dat_i <= {24'h0, d};
      i = 0;
      do begin
         @(posedge MCLK);
         i++;
      end while (ack !== 1'b1 && i < 20);
      q = dat_o[7:0];
      cyc_i <= 1'b0;
      if (i >= 20) begin
         n_mismatch++;
         final_report;
      end
   endtask
   task automatic wr(logic [9:0] a, logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd(logic [9:0] a, logic [7:0] e, string nm);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(nm, q, e);
   endtask
   task automatic wirq(output int t);
      int i;
      // Let the clearing write land first, so a stale flag is not taken.
      for (i = 0; i < 10000; i++) begin
         @(posedge MCLK);
         if (irq === 1'b1)
            break;
      end
      t = cyc;
      if (i >= 10000) begin
         n_mismatch++;
         final_report;
      end
   endtask
   task automatic upto(int t);
      while (cyc < t)
         @(posedge MCLK);
   endtask
   task automatic per(logic [7:0] m, int e);
      int t0, t1;
      wr(A_MODE, m);
      wr(A_COUNT, 8'h00);
      wr(A_STAT, 8'h00);
      wirq(t0);
      wr(A_STAT, 8'h00);
      wirq(t1);
      chk("period", t1 - t0, e);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic reset_regs;
      rd(A_COUNT, 8'h00, "count");
      wr(A_RELOAD, 8'h55);
      rd(A_RELOAD, 8'h00, "reload");
      rd(10'h3fc, 8'h00, "unmapped");
      wr(A_STAT, 8'h02);
      @(posedge MCLK);
      chk("ien", ien, 1'b1);
   endtask
   task automatic rates;
      for (int r = 0; r < 8; r++)
         per(8'h87 | (8'(r) << 4), 16 * (256 >> r));
      for (int c = 0; c < 4; c++)
         per(8'hf1 | (8'(c) << 1), 2 * mods[c]);
   endtask
   task automatic pwm_duty;
      int t0;
      logic [7:0] q;
      wr(A_RELOAD, 8'h04);
      wr(A_MODE, 8'hf7);
      wr(A_STAT, 8'h00);
      wirq(t0);
      wr(A_STAT, 8'h00);
      wirq(t0);
      chk("alt", alt, 1'b1);
      wr(A_RELOAD, 8'h02);
      upto(t0 + 24);
      chk("high1", last_hi, 8);
      upto(t0 + 56);
      chk("high2", last_hi, 4);
      wr(A_RELOAD, 8'h00);
      upto(t0 + 90);
      clr <= 1'b1;
      @(posedge MCLK);
      clr <= 1'b0;
      upto(t0 + 160);
      chk("high0", last_hi, 0);
      wr(A_RELOAD, 8'h0f);
      upto(t0 + 230);
      wr(A_MODE, 8'h77);
      repeat (2) @(posedge MCLK);
      chk("stopped", pin, 1'b0);
      wb(1'b0, A_COUNT, 8'h00, q);
      repeat (20) @(posedge MCLK);
      rd(A_COUNT, q, "hold");
   endtask
   task automatic buzzer;
      int t0;
      wr(A_COUNT, 8'hf0);
      wr(A_RELOAD, 8'hf0);
      wr(A_MODE, 8'hf6);
      wr(A_STAT, 8'h00);
      wirq(t0);
      upto(t0 + 16);
      clr <= 1'b1;
      @(posedge MCLK);
      clr <= 1'b0;
      upto(t0 + 336);
      chk("toggles", edges, 10);
      chk("alt", alt, 1'b1);
   endtask
   task automatic reload_timer;
      int t0;
      wr(A_MODE, 8'h04);
      wr(A_COUNT, 8'hff);
      wr(A_RELOAD, 8'h40);
      wr(A_STAT, 8'h00);
      wr(A_MODE, 8'h84);
      wirq(t0);
      rd(A_COUNT, 8'h40, "reloaded");
   endtask
   task automatic events;
      int n0;
      wr(A_MODE, 8'hf8);
      wr(A_COUNT, 8'hfe);
      wr(A_STAT, 8'h00);
      n0 = n_pin_irq;
      u_tcp_pin_model.pulse(3);
      repeat (8) @(posedge MCLK);
      rd(A_COUNT, 8'h01, "events");
      chk("wrap", irq, 1'b1);
      chk("pin irq", n_pin_irq, n0);
      wr(A_MODE, 8'h00);
      u_tcp_pin_model.pulse(1);
      repeat (8) @(posedge MCLK);
      chk("pin irq", n_pin_irq, n0 + 1);
   endtask
   initial begin
      {RESET, cyc_i, we_i, clr} = 4'b1000;
      adr_i = '0;
      dat_i = '0;
      {cyc, n_pin_irq, n_mismatch, n_tests} = '0;
      repeat (12) @(posedge MCLK);
      RESET <= 1'b0;
      reset_regs;
      rates;
      pwm_duty;
      buzzer;
      reload_timer;
      events;
      final_report;
   end
   initial begin
      #900000;
      n_mismatch++;
      final_report;
   end
endmodule // tcp_timer_bench
